// File: hw/drcp_pkg.sv
/*
  Constants, register defaults and state types of the register control port.
  Assumes a single 125 MHz clock shared by both ends of the link.
*/
package drcp_pkg;
  // ************************************
  // Timing
  // ************************************
  localparam int CLK_NS         = 8;
  localparam int TW_QUARTER_NS  = 50;
  localparam int I2C_QUARTER_NS = 625;
  localparam logic [6:0] TW_QUARTER_CYC  = 7'((TW_QUARTER_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [6:0] I2C_QUARTER_CYC = 7'((I2C_QUARTER_NS + CLK_NS - 1) / CLK_NS);

  // ************************************
  // Frame layout and addressing
  // ************************************
  localparam int DRCP_NREGS      = 22;
  localparam logic [4:0] DRCP_LAST_ADDR = 5'h15;
  localparam logic [4:0] DRCP_SLAVE_ID  = 5'h04;
  localparam logic [4:0] TW_EDGES       = 5'h10;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [3:0] TW_LAST_BIT    = 4'hF;
  localparam int TW_CHIP_POS = 14;
  localparam int TW_DIR_POS  = 13;
  localparam int TW_ADDR_POS = 8;

  // ************************************
  // Register defaults, address 00 in the low byte
  // ************************************
  localparam logic [175:0] DRCP_REG_DEFAULTS = {
    8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h50, 8'h00, 8'h00, 8'h0C,
    8'h0D, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h22, 8'h0C};

  // ************************************
  // States
  // ************************************
  typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_MACK} drcp_i2c_st_t;
  typedef enum logic [1:0] {PH_SLAVE, PH_REG, PH_DATA} drcp_phase_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_TW, H_TW_END} drcp_host_st_t;

  function automatic logic [4:0] drcp_next_addr(input logic [4:0] a);
    drcp_next_addr = (a >= DRCP_LAST_ADDR) ? 5'h00 : 5'(a + 5'h01);
  endfunction
endpackage

// File: hw/drcp_if.sv
/*
  Link between the host end and the device end of the register control port.
  Assumes a pull-up on the data line: it reads high unless an end drives it.
*/
`timescale 1ns/1ps
interface drcp_if;
  logic serial_select_low;
  logic serial_control_clock;
  logic serial_control_data_in;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic power_down_pin_n;
  wire  sda;

  // Wired-and of the open-drain data line
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (output serial_select_low, serial_control_clock, serial_control_data_in,
                output scl, host_sda_o, host_sda_oe_n, power_down_pin_n, input sda);
  modport device (input serial_select_low, serial_control_clock, serial_control_data_in,
                  input scl, power_down_pin_n, sda, output dev_sda_o, dev_sda_oe_n);
endinterface // drcp_if

// File: hw/drcp_device.sv
/*
  Device end: register file with three-wire and two-wire slave access.
  Assumes link pins and straps arrive asynchronously; all are synchronised.
*/
`timescale 1ns/1ps
module drcp_device
  import drcp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  drcp_if.device          link,
  input  wire logic       bus_type_i2c_i,
  input  wire logic       pin_control_select_i,
  input  wire logic       device_address_pin_high_i,
  input  wire logic       device_address_pin_low_i,
  input  wire logic [4:0] cfg_addr_i,
  output logic      [7:0] cfg_data_o,
  output logic            digital_reset_o,
  output logic            mode_i2c_o,
  output logic            wr_pulse_o,
  output logic      [4:0] wr_addr_o,
  output logic      [7:0] wr_data_o
);
  // ************************************
  // Synchronisers
  // ************************************
  logic [8:0] meta_reg;
  logic [8:0] sync_reg;
  logic [2:0] prev_reg;
  wire  [8:0] pins_raw = {link.power_down_pin_n, link.serial_select_low,
                          link.serial_control_clock, link.serial_control_data_in,
                          link.scl, link.sda, bus_type_i2c_i, pin_control_select_i,
                          device_address_pin_high_i ^ 1'b0};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 9'h1D8;
      sync_reg <= 9'h1D8;
    end else begin
      meta_reg <= pins_raw;
      sync_reg <= meta_reg;
    end
  end

  logic addr_lo_meta_reg;
  logic addr_lo_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_lo_meta_reg <= 1'b0;
      addr_lo_reg      <= 1'b0;
    end else begin
      addr_lo_meta_reg <= device_address_pin_low_i;
      addr_lo_reg      <= addr_lo_meta_reg;
    end
  end

  wire       pdn_n    = sync_reg[8];
  wire       sel_low  = sync_reg[7];
  wire       tw_clk   = sync_reg[6];
  wire       tw_data  = sync_reg[5];
  wire       scl      = sync_reg[4];
  wire       sda      = sync_reg[3];
  wire [1:0] cad      = {sync_reg[0], addr_lo_reg};
  wire       mode_i2c = sync_reg[2] & ~sync_reg[1];
  wire       mode_tw  = ~sync_reg[2];
  wire       clr_all  = rst_i | ~pdn_n;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 3'b111;
    end else begin
      prev_reg <= {sel_low, tw_clk, scl};
    end
  end

  logic sda_prev_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_prev_reg <= 1'b1;
    end else begin
      sda_prev_reg <= sda;
    end
  end

  wire sel_rise = sel_low & ~prev_reg[2];
  wire tw_rise  = tw_clk & ~prev_reg[1];
  wire scl_rise = scl & ~prev_reg[0];
  wire scl_fall = ~scl & prev_reg[0];
  wire i2c_start = scl & prev_reg[0] & sda_prev_reg & ~sda;
  wire i2c_stop  = scl & prev_reg[0] & ~sda_prev_reg & sda;

  // ************************************
  // Three-wire receiver
  // ************************************
  logic [15:0] tw_sh_reg;
  logic [4:0]  tw_cnt_reg;

  always_ff @(posedge clk_i) begin
    if (clr_all || sel_low) begin
      tw_cnt_reg <= 5'h00;
    end else if (tw_rise) begin
      tw_sh_reg  <= {tw_sh_reg[14:0], tw_data};
      tw_cnt_reg <= (tw_cnt_reg == 5'h1F) ? tw_cnt_reg : 5'(tw_cnt_reg + 5'h01);
    end
  end

  wire [4:0] tw_addr = tw_sh_reg[TW_ADDR_POS +: 5];
  wire tw_count_ok = (tw_cnt_reg == TW_EDGES);
  wire tw_chip_ok  = (tw_sh_reg[TW_CHIP_POS +: 2] == cad);
  wire tw_commit = mode_tw & pdn_n & sel_rise & tw_count_ok & tw_chip_ok
                   & tw_sh_reg[TW_DIR_POS] & (tw_addr <= DRCP_LAST_ADDR);

  // ************************************
  // Two-wire slave
  // ************************************
  drcp_i2c_st_t st_reg;
  drcp_phase_t  ph_reg;
  logic [7:0]   sh_reg;
  logic [3:0]   cnt_reg;
  logic [4:0]   ptr_reg;
  logic         rd_reg;
  logic         mack_reg;
  logic         drive_reg;
  logic [7:0]   regs_reg [0:DRCP_NREGS-1];

  wire byte_done = (st_reg == I2C_RX) & scl_fall & (cnt_reg == BYTE_BITS);
  wire addr_hit  = (sh_reg[7:1] == {DRCP_SLAVE_ID, cad});
  wire i2c_wr    = byte_done & (ph_reg == PH_DATA) & (ptr_reg <= DRCP_LAST_ADDR);
  wire [7:0] rd_byte = (ptr_reg <= DRCP_LAST_ADDR) ? regs_reg[ptr_reg] : 8'h00;

  always_ff @(posedge clk_i) begin
    if (clr_all || !mode_i2c) begin
      st_reg    <= I2C_IDLE;
      ph_reg    <= PH_SLAVE;
      cnt_reg   <= 4'h0;
      ptr_reg   <= 5'h00;
      rd_reg    <= 1'b0;
      mack_reg  <= 1'b1;
      drive_reg <= 1'b0;
      sh_reg    <= 8'h00;
    end else if (i2c_start) begin
      st_reg    <= I2C_RX;
      ph_reg    <= PH_SLAVE;
      cnt_reg   <= 4'h0;
      drive_reg <= 1'b0;
    end else if (i2c_stop) begin
      st_reg    <= I2C_IDLE;
      drive_reg <= 1'b0;
    end else begin
      case (st_reg)
        I2C_RX: begin
          if (scl_rise) begin
            sh_reg  <= {sh_reg[6:0], sda};
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end else if (byte_done) begin
            cnt_reg   <= 4'h0;
            st_reg    <= I2C_ACK;
            drive_reg <= 1'b1;
            if (ph_reg == PH_SLAVE) begin
              if (addr_hit) begin
                rd_reg <= sh_reg[0];
                ph_reg <= PH_REG;
              end else begin
                st_reg    <= I2C_IDLE;
                drive_reg <= 1'b0;
              end
            end else if (ph_reg == PH_REG) begin
              ptr_reg <= sh_reg[4:0];
              ph_reg  <= PH_DATA;
            end else begin
              ptr_reg <= drcp_next_addr(ptr_reg);
            end
          end
        end
        I2C_ACK, I2C_MACK: begin
          if (st_reg == I2C_MACK && scl_rise) begin
            mack_reg <= sda;
          end else if (scl_fall) begin
            if (rd_reg && (st_reg == I2C_ACK || !mack_reg)) begin
              sh_reg    <= rd_byte;
              ptr_reg   <= drcp_next_addr(ptr_reg);
              drive_reg <= ~rd_byte[7];
              cnt_reg   <= 4'h0;
              st_reg    <= I2C_TX;
            end else if (rd_reg) begin
              st_reg    <= I2C_IDLE;
              drive_reg <= 1'b0;
            end else begin
              st_reg    <= I2C_RX;
              drive_reg <= 1'b0;
            end
          end
        end
        I2C_TX: begin
          if (scl_rise) begin
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end else if (scl_fall) begin
            if (cnt_reg == BYTE_BITS) begin
              drive_reg <= 1'b0;
              mack_reg  <= 1'b1;
              st_reg    <= I2C_MACK;
            end else begin
              sh_reg    <= {sh_reg[6:0], 1'b0};
              drive_reg <= ~sh_reg[6];
            end
          end
        end
        default: begin
          drive_reg <= 1'b0;
        end
      endcase
    end
  end

  // Three-wire path has no driver onto the data line
  assign link.dev_sda_o    = 1'b0;
  assign link.dev_sda_oe_n = ~drive_reg;

  // ************************************
  // Register file
  // ************************************
  always_ff @(posedge clk_i) begin
    if (clr_all) begin
      for (int i = 0; i < DRCP_NREGS; i++) begin
        regs_reg[i] <= DRCP_REG_DEFAULTS[i*8 +: 8];
      end
    end else if (tw_commit) begin
      regs_reg[tw_addr] <= tw_sh_reg[7:0];
    end else if (i2c_wr) begin
      regs_reg[ptr_reg] <= sh_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_data_o      <= 8'h00;
      digital_reset_o <= 1'b1;
      mode_i2c_o      <= 1'b0;
      wr_pulse_o      <= 1'b0;
      wr_addr_o       <= 5'h00;
      wr_data_o       <= 8'h00;
    end else begin
      cfg_data_o      <= (cfg_addr_i <= DRCP_LAST_ADDR) ? regs_reg[cfg_addr_i] : 8'h00;
      digital_reset_o <= ~regs_reg[0][0];
      mode_i2c_o      <= mode_i2c;
      wr_pulse_o      <= tw_commit | i2c_wr;
      wr_addr_o       <= tw_commit ? tw_addr : ptr_reg;
      wr_data_o       <= tw_commit ? tw_sh_reg[7:0] : sh_reg;
    end
  end
endmodule // drcp_device

// File: hw/drcp_host.sv
/*
  Host end: issues one register write per command over either bus; a read goes over two-wire only.
  Assumes the device end answers on the shared open-drain data line.
*/
`timescale 1ns/1ps
module drcp_host
  import drcp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  drcp_if.host            link,
  input  wire logic       power_down_i,
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_i2c_i,
  input  wire logic       cmd_read_i,
  input  wire logic [1:0] cmd_chip_i,
  input  wire logic [4:0] cmd_addr_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            rsp_valid_o,
  output logic            rsp_nack_o,
  output logic      [7:0] rsp_data_o
);
  // ************************************
  // State and divider
  // ************************************
  drcp_host_st_t st_reg;
  logic [6:0]  div_reg;
  logic [1:0]  ph_reg;
  logic [3:0]  bit_reg;
  logic [1:0]  bidx_reg;
  logic [7:0]  sh_reg;
  logic [15:0] tw_sh_reg;
  logic        i2c_reg;
  logic        rd_reg;
  logic        ack_reg;
  logic [1:0]  chip_reg;
  logic [4:0]  addr_reg;
  logic [7:0]  data_reg;
  logic        sda_meta_reg;
  logic        sda_reg;
  logic        drive_reg;
  logic        scl_reg;

  wire busy   = (st_reg != H_IDLE);
  wire tick   = busy & (div_reg == 7'h00);
  wire is_rx  = rd_reg & (bidx_reg == 2'h3);
  wire [7:0] tx_byte = (bidx_reg == 2'h0) ? {DRCP_SLAVE_ID, chip_reg, 1'b0} :
                       (bidx_reg == 2'h1) ? {3'b000, addr_reg} :
                       (bidx_reg == 2'h3) ? 8'hFF :
                       rd_reg ? {DRCP_SLAVE_ID, chip_reg, 1'b1} : data_reg;
  wire accept = cmd_valid_i & cmd_ready_o;
  wire quarter_i2c = busy ? i2c_reg : cmd_i2c_i;

  assign cmd_ready_o = ~busy & ~rsp_valid_o & ~power_down_i;

  always_ff @(posedge clk_i) begin
    if (rst_i || !busy || div_reg == 7'h00) begin
      div_reg <= (quarter_i2c ? I2C_QUARTER_CYC : TW_QUARTER_CYC) - 7'h01;
    end else begin
      div_reg <= 7'(div_reg - 7'h01);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_meta_reg <= 1'b1;
      sda_reg      <= 1'b1;
    end else begin
      sda_meta_reg <= link.sda;
      sda_reg      <= sda_meta_reg;
    end
  end

  // ************************************
  // Sequencer
  // ************************************
  always_ff @(posedge clk_i) begin
    rsp_valid_o <= 1'b0;
    if (rst_i) begin
      st_reg <= H_IDLE;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      bidx_reg <= 2'h0;
      i2c_reg <= 1'b0;
      rd_reg <= 1'b0;
      ack_reg <= 1'b1;
      drive_reg <= 1'b0;
      scl_reg <= 1'b1;
      link.serial_select_low <= 1'b1;
      link.serial_control_clock <= 1'b1;
      link.serial_control_data_in <= 1'b0;
      rsp_nack_o <= 1'b0;
      rsp_data_o <= 8'h00;
    end else if (st_reg == H_IDLE) begin
      if (accept) begin
        {i2c_reg, rd_reg, chip_reg, addr_reg, data_reg} <=
          {cmd_i2c_i, cmd_read_i, cmd_chip_i, cmd_addr_i, cmd_data_i};
        tw_sh_reg <= {cmd_chip_i, 1'b1, cmd_addr_i, cmd_data_i};
        bidx_reg <= 2'h0;
        bit_reg <= 4'h0;
        ph_reg <= 2'h0;
        if (cmd_i2c_i) begin
          st_reg <= H_START;
        end else if (cmd_read_i) begin
          rsp_nack_o <= 1'b1;
          rsp_valid_o <= 1'b1;
        end else begin
          link.serial_select_low <= 1'b0;
          st_reg <= H_TW;
        end
      end
    end else if (tick) begin
      ph_reg <= 2'(ph_reg + 2'h1);
      case (st_reg)
        H_START: begin
          case (ph_reg)
            2'h0: drive_reg <= 1'b0;
            2'h1: scl_reg <= 1'b1;
            2'h2: drive_reg <= 1'b1;
            default: begin
              scl_reg <= 1'b0;
              bit_reg <= 4'h0;
              st_reg <= H_BIT;
            end
          endcase
        end
        H_BIT: begin
          case (ph_reg)
            2'h0: begin
              if (bit_reg == 4'h0) begin
                sh_reg <= tx_byte;
                drive_reg <= ~tx_byte[7];
              end else begin
                drive_reg <= (bit_reg == BYTE_BITS) ? 1'b0 : ~sh_reg[7];
              end
            end
            2'h1: scl_reg <= 1'b1;
            2'h2: begin
              if (bit_reg == BYTE_BITS) begin
                ack_reg <= sda_reg;
              end else begin
                sh_reg <= {sh_reg[6:0], sda_reg};
              end
            end
            default: begin
              scl_reg <= 1'b0;
              bit_reg <= 4'(bit_reg + 4'h1);
              if (bit_reg == BYTE_BITS) begin
                bit_reg <= 4'h0;
                bidx_reg <= 2'(bidx_reg + 2'h1);
                if (is_rx || ack_reg) begin
                  rsp_nack_o <= ~is_rx & ack_reg;
                  rsp_data_o <= sh_reg;
                  st_reg <= H_STOP;
                end else if (rd_reg && bidx_reg == 2'h1) begin
                  st_reg <= H_START;
                end else if (!rd_reg && bidx_reg == 2'h2) begin
                  rsp_nack_o <= 1'b0;
                  st_reg <= H_STOP;
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (ph_reg)
            2'h0: drive_reg <= 1'b1;
            2'h1: scl_reg <= 1'b1;
            2'h2: drive_reg <= 1'b0;
            default: begin
              rsp_valid_o <= 1'b1;
              st_reg <= H_IDLE;
            end
          endcase
        end
        H_TW: begin
          case (ph_reg)
            2'h0: begin
              link.serial_control_clock <= 1'b0;
              link.serial_control_data_in <= tw_sh_reg[15];
            end
            2'h2: link.serial_control_clock <= 1'b1;
            2'h3: begin
              tw_sh_reg <= {tw_sh_reg[14:0], 1'b0};
              bit_reg <= 4'(bit_reg + 4'h1);
              if (bit_reg == TW_LAST_BIT) begin
                st_reg <= H_TW_END;
              end
            end
            default: begin
            end
          endcase
        end
        default: begin
          if (ph_reg == 2'h1) begin
            link.serial_select_low <= 1'b1;
            rsp_nack_o <= 1'b0;
            rsp_valid_o <= 1'b1;
            st_reg <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.scl              = scl_reg;
  assign link.host_sda_o       = 1'b0;
  assign link.host_sda_oe_n    = ~drive_reg;
  assign link.power_down_pin_n = ~power_down_i;
endmodule // drcp_host

// File: tb/drcp_props.sv
/*
  Checker of the link between host end and device end.
  Assumes one clock domain; instantiated beside the interface in tb_top.
*/
`timescale 1ns/1ps
module drcp_props (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic serial_select_low,
  input  wire logic serial_control_clock,
  input  wire logic serial_control_data_in,
  input  wire logic scl,
  input  wire logic host_sda_oe_n,
  input  wire logic dev_sda_oe_n,
  input  wire logic power_down_pin_n,
  input  wire logic sda
);
  // ************************************
  // Helper counters
  // ************************************
  logic       serial_control_clock_reg;
  logic [5:0] rise_reg;
  logic [8:0] low_reg;

  always_ff @(posedge clk_i) begin
    serial_control_clock_reg <= serial_control_clock;
    if (rst_i || serial_select_low) rise_reg <= 6'h00;
    else if (serial_control_clock && !serial_control_clock_reg) rise_reg <= rise_reg + 6'h01;
    if (rst_i || scl) low_reg <= 9'h000;
    else if (low_reg != 9'h1FF) low_reg <= low_reg + 9'h001;
  end

  // ************************************
  // Properties
  // ************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence

  a_frame_sixteen_edges: assert property ($rose(serial_select_low) |-> rise_reg == 6'h10)
    else $error("three-wire frame without sixteen clock rises");
  a_tw_data_stable: assert property (!serial_select_low && serial_control_clock
    && $past(serial_control_clock) |-> $stable(serial_control_data_in))
    else $error("three-wire data moved while clock high");
  a_tw_clock_high: assert property ($rose(serial_control_clock) && !serial_select_low
    |=> serial_control_clock [*8])
    else $error("three-wire clock high phase too short");
  a_scl_low_time: assert property ($rose(scl) |-> low_reg >= 9'h096)
    else $error("two-wire clock low phase too short");
  a_no_tw_readback: assert property (!serial_select_low |-> dev_sda_oe_n)
    else $error("device drove data during three-wire frame");
  a_ack_host_released: assert property (!dev_sda_oe_n && $rose(scl) |-> host_sda_oe_n)
    else $error("host held data line during device bit");
  a_dev_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device changed data line while clock high");
  a_start_then_low: assert property (s_start |-> ##[60:100] !scl)
    else $error("no clock low after start");
  a_stop_then_idle: assert property (s_stop |-> scl [*8])
    else $error("clock moved after stop");
  a_power_down_idle: assert property (!power_down_pin_n
    |-> serial_select_low && scl && host_sda_oe_n)
    else $error("host active during power down");
endmodule // drcp_props

// File: tb/tb_top.sv
/*
  Self-checking bench: host end and device end joined by the link interface.
  Assumes the shared package; a register model predicts every register readback.
*/
`timescale 1ns/1ps
module tb_top
  import drcp_pkg::*;
;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       bus_i2c = 1'b0, pin_sel = 1'b0, pin_hi = 1'b0, pin_lo = 1'b0, pd = 1'b0;
  logic       cv = 1'b0, ci2c = 1'b0, crd = 1'b0;
  logic [1:0] cchip = 2'h0;
  logic [4:0] caddr = 5'h00, cfg_addr = 5'h00, wr_addr, wa;
  logic [7:0] cdata = 8'h00, cfg_data, rsp_data, wr_data, wd, rdv;
  logic       dres, mode, wrp, crdy, rv, rn, rnv, seen_wr;
  logic [4:0] att[8] = '{5'h03, 5'h04, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
  int         mdl[22];
  int         miscompares = 0;
  int         samples_checked = 0;

  always #4 clk_i = ~clk_i;

  drcp_if link ();
  drcp_device drcp_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .bus_type_i2c_i(bus_i2c), .pin_control_select_i(pin_sel),
    .device_address_pin_high_i(pin_hi), .device_address_pin_low_i(pin_lo),
    .cfg_addr_i(cfg_addr), .cfg_data_o(cfg_data), .digital_reset_o(dres),
    .mode_i2c_o(mode), .wr_pulse_o(wrp), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  drcp_host drcp_host_i (.clk_i(clk_i), .rst_i(rst_i), .link(link), .power_down_i(pd),
    .cmd_valid_i(cv), .cmd_ready_o(crdy), .cmd_i2c_i(ci2c), .cmd_read_i(crd),
    .cmd_chip_i(cchip), .cmd_addr_i(caddr), .cmd_data_i(cdata),
    .rsp_valid_o(rv), .rsp_nack_o(rn), .rsp_data_o(rsp_data));
  drcp_props drcp_props_i (.clk_i(clk_i), .rst_i(rst_i),
    .serial_select_low(link.serial_select_low), .serial_control_clock(link.serial_control_clock),
    .serial_control_data_in(link.serial_control_data_in), .scl(link.scl),
    .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n),
    .power_down_pin_n(link.power_down_pin_n), .sda(link.sda));

  // ************************************
  // Tasks
  // ************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic run(input logic i2c, rd, input logic [1:0] chip, input logic [4:0] a,
                     input logic [7:0] d);
    int n;
    int left;
    logic got;
    n = 0;
    left = 24;
    got = 1'b0;
    seen_wr = 1'b0;
    cv <= 1'b1;
    ci2c <= i2c;
    crd <= rd;
    cchip <= chip;
    caddr <= a;
    cdata <= d;
    @(posedge clk_i);
    cv <= 1'b0;
    while (left > 0 && n < 20000) begin
      @(posedge clk_i);
      n++;
      if (wrp === 1'b1) begin
        seen_wr = 1'b1;
        wa = wr_addr;
        wd = wr_data;
      end
      if (rv === 1'b1) begin
        got = 1'b1;
        rnv = rn;
        rdv = rsp_data;
      end
      if (got) left--;
    end
    if (!got) begin
      miscompares++;
      $display("mismatch rsp_wait expected 1 seen 0");
      summarize();
    end
  endtask

  task automatic wr_ok(input logic [4:0] a, input logic [7:0] d);
    chk("nack", {7'h00, rnv}, 8'h00);
    chk("wr_seen", {7'h00, seen_wr}, 8'h01);
    chk("wr_addr", {3'h0, wa}, {3'h0, a});
    chk("wr_data", wd, d);
    mdl[a] = d;
  endtask

  task automatic check_all();
    for (int i = 0; i < 23; i++) begin
      cfg_addr <= 5'(i);
      @(posedge clk_i);
      @(posedge clk_i);
      chk("cfg_data", cfg_data, (i < 22) ? 8'(mdl[i]) : 8'h00);
    end
  endtask

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    logic [1:0] chip;
    logic [4:0] a;
    logic [7:0] d;
    void'($urandom(32'h2795));
    for (int i = 0; i < 22; i++) mdl[i] = int'(DRCP_REG_DEFAULTS[i*8 +: 8]);
    chip = 2'($urandom());
    {pin_hi, pin_lo} <= chip;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check_all();
    chk("dres", {7'h00, dres}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      a = att[$urandom_range(7, 0)];
      d = 8'($urandom());
      run(1'b0, 1'b0, chip, a, d);
      wr_ok(a, d);
    end
    run(1'b0, 1'b0, chip, 5'h15, 8'hA0);
    wr_ok(5'h15, 8'hA0);
    run(1'b0, 1'b0, ~chip, 5'h03, 8'h11);
    chk("wr_seen", {7'h00, seen_wr}, 8'h00);
    run(1'b0, 1'b1, chip, 5'h03, 8'h00);
    chk("tw_read_nack", {7'h00, rnv}, 8'h01);
    run(1'b0, 1'b0, chip, 5'h00, 8'h0D);
    wr_ok(5'h00, 8'h0D);
    repeat (4) @(posedge clk_i);
    chk("dres", {7'h00, dres}, 8'h00);
    check_all();
    $display("test three_wire done");
    bus_i2c <= 1'b1;
    pin_sel <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("mode", {7'h00, mode}, 8'h00);
    pin_sel <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("mode", {7'h00, mode}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      a = att[$urandom_range(7, 0)];
      d = 8'($urandom());
      run(1'b1, 1'b0, chip, a, d);
      wr_ok(a, d);
      run(1'b1, 1'b1, chip, a, 8'h00);
      chk("rd_nack", {7'h00, rnv}, 8'h00);
      chk("rd_data", rdv, 8'(mdl[a]));
    end
    run(1'b1, 1'b0, chip ^ 2'h1, 5'h04, 8'h5A);
    chk("foreign_nack", {7'h00, rnv}, 8'h01);
    chk("wr_seen", {7'h00, seen_wr}, 8'h00);
    $display("test two_wire done");
    pd <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("ready_pd", {7'h00, crdy}, 8'h00);
    pd <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("ready", {7'h00, crdy}, 8'h01);
    for (int i = 0; i < 22; i++) mdl[i] = int'(DRCP_REG_DEFAULTS[i*8 +: 8]);
    check_all();
    chk("dres", {7'h00, dres}, 8'h01);
    $display("test power_down done");
    summarize();
  end
endmodule // tb_top
